// *** bench/bus_master_model.sv ***
// Bus master model that issues memory accesses and flash commands.
`timescale 1ns/1ps
module bus_master_model #(
	parameter int PAGE_BITS = 11
) (
	input  wire logic             clk_sys,
	output logic                  acc_valid,
	output logic [31:0]           acc_addr,
	output logic                  acc_from_debug,
	output logic                  cmd_valid,
	output nvm_map_pkg::cmd_e     cmd_code,
	output logic [PAGE_BITS-1:0]  cmd_page,
	output logic [1:0]            cmd_bit,
	input  wire logic             cmd_done
);
	// ----------------------------------------------------------------
	// Request drivers
	// ----------------------------------------------------------------
	// Released fields other than cmd_code show the inverse of the last value, so a design that
	// samples outside its take edge does not get lucky.
	initial begin
		acc_valid = 1'b0;
		acc_addr = 32'hFFFF_FFFF;
		acc_from_debug = 1'b0;
		cmd_valid = 1'b0;
		cmd_code = nvm_map_pkg::CMD_NOP;
		cmd_page = '0;
		cmd_bit = 2'h0;
	end

	task automatic access(input logic [31:0] addr, input logic dbg);
		@(posedge clk_sys);
		#1;
		acc_valid = 1'b1;
		acc_addr = addr;
		acc_from_debug = dbg;
		@(posedge clk_sys);
		#1;
		acc_valid = 1'b0;
		acc_addr = ~addr;
		acc_from_debug = ~dbg;
	endtask : access

	task automatic command(input nvm_map_pkg::cmd_e code, input logic [PAGE_BITS-1:0] page,
		input logic [1:0] gbit, output int lat);
		@(posedge clk_sys);
		#1;
		cmd_valid = 1'b1;
		cmd_code = code;
		cmd_page = page;
		cmd_bit = gbit;
		@(posedge clk_sys);
		#1;
		cmd_valid = 1'b0;
		cmd_code = nvm_map_pkg::CMD_NOP;
		cmd_page = ~page;
		cmd_bit = ~gbit;
		// Latency counts the edges from the take edge to the edge that raised the done pulse.
		lat = 0;
		while (cmd_done !== 1'b1 && lat < 200) begin
			@(posedge clk_sys);
			#1;
			lat++;
		end
	endtask : command
endmodule : bus_master_model

// *** bench/memory_map_flash_nvm_control_tb.sv ***
// Self-checking bench for the memory map decoder and non-volatile control.
`timescale 1ns/1ps
module memory_map_flash_nvm_control_tb;
	// ----------------------------------------------------------------
	// Wiring
	// ----------------------------------------------------------------
	localparam logic [15:0] CALIB = 16'h5A3C;
	typedef struct {
		logic [31:0]          addr;
		nvm_map_pkg::target_e tgt;
		logic [7:0]           sel;
		logic                 abort;
	} row_s;
	logic clk_sys, system_reset_pin, acc_valid, acc_from_debug, acc_abort, cmd_valid, cmd_done, lock_error_irq;
	logic wbuf_we, prog_we, erase_page_req, erase_all_req, erase_pin, test_mode_pin, fast_prog_mode;
	logic port_a_line_0, port_a_line_1, port_a_line_2, remapped, security;
	logic brownout_detector_en, brownout_reset_en;
	logic [31:0]          acc_addr, wbuf_data, prog_data, lock_bits;
	nvm_map_pkg::target_e acc_target;
	nvm_map_pkg::cmd_e    cmd_code;
	logic [7:0]           ext_select_n;
	logic [19:0]          acc_offset;
	logic [10:0]          cmd_page, prog_page;
	logic [1:0]           cmd_bit;
	logic [5:0]           wbuf_idx, prog_idx;
	logic [2:0]           general_purpose_nv_bit;
	logic [15:0]          calib_bits;
	int failures = 0, tests_run = 0, lat, n, prog_beats = 0, irq_seen = 0, epage_seen = 0, eall_seen = 0;
	row_s rows [11] = '{
		'{32'h0000_0010, nvm_map_pkg::TGT_ROM, 8'hFF, 1'b0}, '{32'h0010_0004, nvm_map_pkg::TGT_FLASH, 8'hFF, 1'b0},
		'{32'h0020_0000, nvm_map_pkg::TGT_SRAM, 8'hFF, 1'b0}, '{32'h0030_0100, nvm_map_pkg::TGT_ROM, 8'hFF, 1'b0},
		'{32'h0040_0000, nvm_map_pkg::TGT_NONE, 8'hFF, 1'b1}, '{32'h1000_0000, nvm_map_pkg::TGT_EXT, 8'hFE, 1'b0},
		'{32'h3000_0000, nvm_map_pkg::TGT_EXT, 8'hFB, 1'b0}, '{32'h8FFF_FFFC, nvm_map_pkg::TGT_EXT, 8'h7F, 1'b0},
		'{32'h9000_0000, nvm_map_pkg::TGT_NONE, 8'hFF, 1'b1}, '{32'hE123_4568, nvm_map_pkg::TGT_NONE, 8'hFF, 1'b1},
		'{32'hFFFF_F000, nvm_map_pkg::TGT_PERIPH, 8'hFF, 1'b0}};

	nvm_map_ctrl #(.PAGE_BITS(11), .SLOW_DIV(4), .ERASE_TICKS(3), .CALIB_VALUE(CALIB)) nvm_map_ctrl_i (
		.clk_sys, .system_reset_pin, .acc_valid, .acc_addr, .acc_from_debug, .acc_abort, .acc_target, .ext_select_n,
		.acc_offset, .cmd_valid, .cmd_code, .cmd_page, .cmd_bit, .cmd_done, .lock_error_irq, .wbuf_we,
		.wbuf_idx, .wbuf_data, .prog_we, .prog_page, .prog_idx, .prog_data, .erase_page_req, .erase_all_req,
		.erase_pin, .test_mode_pin, .port_a_line_0, .port_a_line_1, .port_a_line_2, .fast_prog_mode,
		.remapped, .general_purpose_nv_bit, .lock_bits, .security, .brownout_detector_en,
		.brownout_reset_en, .calib_bits);

	bus_master_model #(.PAGE_BITS(11)) bus_master_model_i (.clk_sys, .acc_valid, .acc_addr,
		.acc_from_debug, .cmd_valid, .cmd_code, .cmd_page, .cmd_bit, .cmd_done);

	initial begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end

	// ----------------------------------------------------------------
	// Checking helpers
	// ----------------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			failures++;
			$display("BAD at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : finish_test

	// Two settle cycles let the brownout copies and the last program beat land.
	task automatic cmd(input nvm_map_pkg::cmd_e code, input logic [10:0] page, input logic [1:0] gbit);
		bus_master_model_i.command(code, page, gbit, lat);
		repeat (2) begin
			@(posedge clk_sys);
			#1;
		end
	endtask : cmd

	always @(posedge clk_sys) begin
		if (prog_we === 1'b1) begin
			check(prog_idx, prog_beats[5:0]);
			check(prog_data, 32'hC0DE_0000 + prog_beats);
			prog_beats++;
		end
		irq_seen += int'(lock_error_irq === 1'b1);
		epage_seen += int'(erase_page_req === 1'b1);
		eall_seen += int'(erase_all_req === 1'b1);
	end

	initial begin
		#200000;
		failures++;
		finish_test();
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		system_reset_pin = 1'b0;
		{erase_pin, test_mode_pin, port_a_line_0, port_a_line_1, port_a_line_2, wbuf_we} = 6'h00;
		wbuf_idx = 6'h00;
		wbuf_data = 32'h0000_0000;
		repeat (4) @(posedge clk_sys);
		#1;
		check(ext_select_n, 8'hFF);
		check({remapped, security, general_purpose_nv_bit, calib_bits}, 32'h0);
		check(lock_bits, 32'h0);
		system_reset_pin = 1'b1;
		foreach (rows[i]) begin
			bus_master_model_i.access(rows[i].addr, 1'b0);
			check(acc_target, rows[i].tgt);
			check(ext_select_n, rows[i].sel);
			check(acc_abort, rows[i].abort);
			if (!rows[i].abort)
				check(acc_offset, rows[i].addr[19:0]);
		end
		check(calib_bits, CALIB);
		cmd(nvm_map_pkg::CMD_SET_GPBIT, 11'd0, 2'd2);
		bus_master_model_i.access(32'h0000_0000, 1'b0);
		check(acc_target, nvm_map_pkg::TGT_FLASH);
		for (int b = 0; b < 4; b++)
			cmd(nvm_map_pkg::CMD_SET_GPBIT, 11'd0, b[1:0]);
		check(general_purpose_nv_bit, 3'h7);
		check({brownout_detector_en, brownout_reset_en}, 2'h3);
		cmd(nvm_map_pkg::CMD_CLR_GPBIT, 11'd0, 2'd0);
		check({general_purpose_nv_bit, brownout_detector_en}, 4'hC);
		cmd(nvm_map_pkg::CMD_SET_LOCK, 11'd2047, 2'd0);
		cmd(nvm_map_pkg::CMD_SET_LOCK, 11'd320, 2'd0);
		check(lock_bits, 32'h8000_0020);
		cmd(nvm_map_pkg::CMD_PAGE_ERASE, 11'd383, 2'd0);
		cmd(nvm_map_pkg::CMD_PAGE_ERASE, 11'd384, 2'd0);
		cmd(nvm_map_pkg::CMD_PAGE_PROG, 11'd2047, 2'd0);
		check({irq_seen[7:0], epage_seen[7:0], prog_beats[7:0]}, 24'h020100);
		cmd(nvm_map_pkg::CMD_CLR_LOCK, 11'd320, 2'd0);
		check(lock_bits, 32'h8000_0000);
		for (int w = 0; w < 64; w++) begin
			@(posedge clk_sys);
			#1;
			wbuf_we = 1'b1;
			wbuf_idx = w[5:0];
			wbuf_data = 32'hC0DE_0000 + w;
		end
		@(posedge clk_sys);
		#1;
		wbuf_we = 1'b0;
		cmd(nvm_map_pkg::CMD_PAGE_PROG, 11'd330, 2'd0);
		check(lat, 64);
		check({prog_beats[7:0], prog_page}, {8'd64, 11'd330});
		cmd(nvm_map_pkg::CMD_SET_SECURITY, 11'd0, 2'd0);
		check(security, 1'b1);
		bus_master_model_i.access(32'h0010_0000, 1'b1);
		check(acc_abort, 1'b1);
		bus_master_model_i.access(32'h0010_0000, 1'b0);
		check(acc_target, nvm_map_pkg::TGT_FLASH);
		{test_mode_pin, port_a_line_0, port_a_line_1} = 3'h7;
		repeat (2) @(posedge clk_sys);
		#1;
		check(fast_prog_mode, 1'b1);
		bus_master_model_i.access(32'h0010_0000, 1'b0);
		check(acc_abort, 1'b1);
		port_a_line_2 = 1'b1;
		repeat (2) @(posedge clk_sys);
		#1;
		check(fast_prog_mode, 1'b0);
		{test_mode_pin, port_a_line_0, port_a_line_1, port_a_line_2} = 4'h0;
		cmd(nvm_map_pkg::CMD_REMAP, 11'd0, 2'd0);
		bus_master_model_i.access(32'h0000_0100, 1'b0);
		check({remapped, 1'b0, acc_target}, {1'b1, 1'b0, nvm_map_pkg::TGT_SRAM});
		bus_master_model_i.access(32'h0020_0000, 1'b0);
		check(acc_target, nvm_map_pkg::TGT_SRAM);
		erase_pin = 1'b1;
		repeat (5) @(posedge clk_sys);
		#1;
		erase_pin = 1'b0;
		repeat (20) @(posedge clk_sys);
		#1;
		check(general_purpose_nv_bit, 3'h6);
		erase_pin = 1'b1;
		for (n = 0; general_purpose_nv_bit !== 3'h0 && n < 100; n++)
			@(posedge clk_sys);
		repeat (2) @(posedge clk_sys);
		#1;
		check({general_purpose_nv_bit, brownout_detector_en, brownout_reset_en}, 5'h00);
		check(lock_bits, 32'h0);
		check({security, calib_bits}, {1'b1, CALIB});
		erase_pin = 1'b0;
		cmd(nvm_map_pkg::CMD_FULL_ERASE, 11'd0, 2'd0);
		check({eall_seen[3:0], security}, 5'h02);
		bus_master_model_i.access(32'h0010_0000, 1'b1);
		check(acc_target, nvm_map_pkg::TGT_FLASH);
		cmd(nvm_map_pkg::CMD_REMAP, 11'd0, 2'd0);
		check(remapped, 1'b1);
		system_reset_pin = 1'b0;
		repeat (2) @(posedge clk_sys);
		#1;
		check({remapped, acc_target, ext_select_n}, {1'b0, nvm_map_pkg::TGT_NONE, 8'hFF});
		system_reset_pin = 1'b1;
		bus_master_model_i.access(32'h0000_0000, 1'b0);
		check(acc_target, nvm_map_pkg::TGT_ROM);
		finish_test();
	end
endmodule : memory_map_flash_nvm_control_tb

// *** logic/nvm_map_ctrl.sv ***
// Memory map decoder with boot remap and the flash controller's non-volatile state.
//
// Contract
// - Top four address bits pick one of sixteen 256 MB areas.
// - Areas one to eight go external, each with its own chip select.
// - Area zero goes to internal memories in 1 MB regions.
// - Area fifteen goes to the peripheral bus.
// - Any other area returns an abort to the requester.
// - SRAM answers at 0x0020_0000, and also at zero after remap.
// - ROM always answers at 0x0030_0000.
// - Flash answers at 0x0010_0000 in every remap state, but a secured debug or fast programming access there aborts.
// - Before remap region zero mirrors flash if boot bit set, else ROM.
// - Accepted erase pin clears the boot bit.
// - Set and clear commands update each general purpose bit.
// - One lock bit per lock region, 32 regions of 16 KB.
// - Program or erase of a locked region aborts and raises an interrupt.
// - Set and clear lock commands update the addressed lock bit.
// - Accepted erase pin clears every lock bit.
// - Security bit set refuses flash access from debug or fast programming port.
// - Security set only by command; cleared by erase pin then full erase.
// - Bit zero drives brownout detector enable; erase pin clears it.
// - Bit one drives brownout reset enable; erase pin clears it.
// - Sixteen calibration bits are read only and ignore the erase pin.
// - Page write buffer of 256 bytes written as 32-bit words.
// - Fast programming mode when test pin, A0, A1 high and A2 low.
// - Erase pin debounced: under 100 ms ignored, over 220 ms accepted.
`timescale 1ns/1ps
`include "nvm_map_defs.svh"

module nvm_map_ctrl #(
	parameter int LOCK_REGIONS  = 32,
	parameter int PAGE_WORDS    = 64,
	parameter int PAGE_BITS     = 11,
	parameter int PAGES_PER_RGN = 64,
	parameter int SLOW_DIV      = `SLOW_DIV_CYCLES,
	parameter int ERASE_TICKS   = `ERASE_ACCEPT_TICKS,
	parameter logic [15:0] CALIB_VALUE = 16'hA5C3
) (
	input  wire logic                    clk_sys,
	input  wire logic                    system_reset_pin,
	input  wire logic                    acc_valid,
	input  wire logic [31:0]             acc_addr,
	input  wire logic                    acc_from_debug,
	output logic                         acc_abort,
	output nvm_map_pkg::target_e         acc_target,
	output logic [7:0]                   ext_select_n,
	output logic [19:0]                  acc_offset,
	input  wire logic                    cmd_valid,
	input  wire nvm_map_pkg::cmd_e       cmd_code,
	input  wire logic [PAGE_BITS-1:0]    cmd_page,
	input  wire logic [1:0]              cmd_bit,
	output logic                         cmd_done,
	output logic                         lock_error_irq,
	input  wire logic                    wbuf_we,
	input  wire logic [$clog2(PAGE_WORDS)-1:0] wbuf_idx,
	input  wire logic [31:0]             wbuf_data,
	output logic                         prog_we,
	output logic [PAGE_BITS-1:0]         prog_page,
	output logic [$clog2(PAGE_WORDS)-1:0] prog_idx,
	output logic [31:0]                  prog_data,
	output logic                         erase_page_req,
	output logic                         erase_all_req,
	input  wire logic                    erase_pin,
	input  wire logic                    test_mode_pin,
	input  wire logic                    port_a_line_0,
	input  wire logic                    port_a_line_1,
	input  wire logic                    port_a_line_2,
	output logic                         fast_prog_mode,
	output logic                         remapped,
	output logic [2:0]                   general_purpose_nv_bit,
	output logic [LOCK_REGIONS-1:0]      lock_bits,
	output logic                         security,
	output logic                         brownout_detector_en,
	output logic                         brownout_reset_en,
	output logic [15:0]                  calib_bits
);
	localparam int IW = $clog2(PAGE_WORDS);
	localparam int RB = $clog2(LOCK_REGIONS);
	localparam int PR = $clog2(PAGES_PER_RGN);

	logic [31:0]   wbuf [PAGE_WORDS];
	logic [15:0]   slow_cnt;
	logic          slow_tick;
	logic [15:0]   erase_cnt;
	logic          erase_accept;
	logic          erase_seen;
	logic          prog_busy;
	logic [IW:0]   prog_cnt;
	logic [RB-1:0] cmd_region;
	logic          cmd_locked;
	logic          cmd_modifies;

	assign cmd_region   = RB'(cmd_page >> PR);
	assign cmd_locked   = lock_bits[cmd_region];
	assign cmd_modifies = (cmd_code == nvm_map_pkg::CMD_PAGE_PROG) || (cmd_code == nvm_map_pkg::CMD_PAGE_ERASE);

	// ----------------------------------------
	// Address decode
	// ----------------------------------------
	logic [3:0] area;
	logic [7:0] region;
	nvm_map_pkg::target_e next_target;
	logic       next_abort;
	logic       flash_target;

	assign area   = acc_addr[`AREA_MSB:`AREA_LSB];
	assign region = acc_addr[`REGION_MSB:`REGION_LSB];

	always_comb begin
		next_target = nvm_map_pkg::TGT_NONE;
		if (area == `AREA_INTERNAL) begin
			unique case (region)
				`REGION_BOOT: begin
					if (remapped)
						next_target = nvm_map_pkg::TGT_SRAM;
					else if (general_purpose_nv_bit[`GPBIT_BOOT_FLASH])
						next_target = nvm_map_pkg::TGT_FLASH;
					else
						next_target = nvm_map_pkg::TGT_ROM;
				end
				`REGION_FLASH: next_target = nvm_map_pkg::TGT_FLASH;
				`REGION_SRAM:  next_target = nvm_map_pkg::TGT_SRAM;
				`REGION_ROM:   next_target = nvm_map_pkg::TGT_ROM;
				default:       next_target = nvm_map_pkg::TGT_NONE;
			endcase
		end else if (area >= `AREA_EXT_FIRST && area <= `AREA_EXT_LAST) begin
			next_target = nvm_map_pkg::TGT_EXT;
		end else if (area == `AREA_PERIPH) begin
			next_target = nvm_map_pkg::TGT_PERIPH;
		end
	end

	assign flash_target = (next_target == nvm_map_pkg::TGT_FLASH);
	// abort on unmapped, secured flash access from debug or in fast programming mode refused
	assign next_abort = (next_target == nvm_map_pkg::TGT_NONE) ||
		(flash_target && security && (acc_from_debug || fast_prog_mode));

	always_ff @(posedge clk_sys) begin
		if (!system_reset_pin) begin
			acc_abort    <= 1'b0;
			acc_target   <= nvm_map_pkg::TGT_NONE;
			ext_select_n <= 8'hFF;
			acc_offset   <= 20'h0_0000;
		end else begin
			acc_abort    <= acc_valid && next_abort;
			acc_target   <= (acc_valid && !next_abort) ? next_target : nvm_map_pkg::TGT_NONE;
			acc_offset   <= acc_addr[19:0];
			ext_select_n <= 8'hFF;
			if (acc_valid && next_target == nvm_map_pkg::TGT_EXT)
				ext_select_n[3'(area - 4'h1)] <= 1'b0;
		end
	end

	// ----------------------------------------
	// Erase pin debounce on a slow tick
	// ----------------------------------------
	always_ff @(posedge clk_sys) begin
		if (!system_reset_pin) begin
			slow_cnt  <= 16'h0000;
			slow_tick <= 1'b0;
		end else begin
			slow_tick <= (slow_cnt == 16'(SLOW_DIV - 1));
			slow_cnt  <= (slow_cnt == 16'(SLOW_DIV - 1)) ? 16'h0000 : slow_cnt + 16'h0001;
		end
	end

	// Only a pulse held past the accept time fires, once, so short glitches never erase.
	always_ff @(posedge clk_sys) begin
		if (!system_reset_pin) begin
			erase_cnt    <= 16'h0000;
			erase_accept <= 1'b0;
		end else begin
			erase_accept <= 1'b0;
			if (!erase_pin)
				erase_cnt <= 16'h0000;
			else if (slow_tick && erase_cnt != 16'(ERASE_TICKS)) begin
				erase_cnt <= erase_cnt + 16'h0001;
				erase_accept <= (erase_cnt == 16'(ERASE_TICKS - 1));
			end
		end
	end

	// ----------------------------------------
	// Fast programming mode strap
	// ----------------------------------------
	always_ff @(posedge clk_sys) begin
		if (!system_reset_pin)
			fast_prog_mode <= 1'b0;
		else
			fast_prog_mode <= ({test_mode_pin, port_a_line_2, port_a_line_1, port_a_line_0} == `FAST_PROG_PATTERN);
	end

	// ----------------------------------------
	// Non-volatile bits and commands
	// ----------------------------------------
	always_ff @(posedge clk_sys) begin
		if (!system_reset_pin)
			remapped <= 1'b0;
		else if (cmd_valid && cmd_code == nvm_map_pkg::CMD_REMAP)
			remapped <= 1'b1;
	end

	// The non-volatile bits model cells that survive reset, but the system reset still gives them a defined start.
	always_ff @(posedge clk_sys) begin
		if (!system_reset_pin)
			general_purpose_nv_bit <= `GPBITS_RESET;
		else if (erase_accept)
			general_purpose_nv_bit <= 3'h0;
		else if (cmd_valid && cmd_code == nvm_map_pkg::CMD_SET_GPBIT && cmd_bit != 2'h3)
			general_purpose_nv_bit[cmd_bit] <= 1'b1;
		else if (cmd_valid && cmd_code == nvm_map_pkg::CMD_CLR_GPBIT && cmd_bit != 2'h3)
			general_purpose_nv_bit[cmd_bit] <= 1'b0;
	end

	always_ff @(posedge clk_sys) begin
		if (!system_reset_pin)
			lock_bits <= LOCK_REGIONS'(`LOCK_RESET);
		else if (erase_accept)
			lock_bits <= '0;
		else if (cmd_valid && cmd_code == nvm_map_pkg::CMD_SET_LOCK)
			lock_bits[cmd_region] <= 1'b1;
		else if (cmd_valid && cmd_code == nvm_map_pkg::CMD_CLR_LOCK)
			lock_bits[cmd_region] <= 1'b0;
	end

	always_ff @(posedge clk_sys) begin
		if (!system_reset_pin) begin
			security   <= 1'b0;
			erase_seen <= 1'b0;
		end else begin
			if (erase_accept)
				erase_seen <= 1'b1;
			// set by command, cleared by erase pin then full erase
			if (cmd_valid && cmd_code == nvm_map_pkg::CMD_SET_SECURITY)
				security <= 1'b1;
			else if (cmd_valid && cmd_code == nvm_map_pkg::CMD_FULL_ERASE && (erase_seen || erase_accept)) begin
				security   <= 1'b0;
				erase_seen <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!system_reset_pin) begin
			brownout_detector_en <= 1'b0;
			brownout_reset_en    <= 1'b0;
			calib_bits           <= 16'h0000;
		end else begin
			brownout_detector_en <= general_purpose_nv_bit[`GPBIT_BOD_EN];
			brownout_reset_en    <= general_purpose_nv_bit[`GPBIT_BOD_RST_EN];
			calib_bits           <= CALIB_VALUE;
		end
	end

	// ----------------------------------------
	// Write buffer and program sequencer
	// ----------------------------------------
	always_ff @(posedge clk_sys) begin
		// page buffer written word by word
		if (wbuf_we)
			wbuf[wbuf_idx] <= wbuf_data;
	end

	always_ff @(posedge clk_sys) begin
		if (!system_reset_pin) begin
			cmd_done       <= 1'b0;
			lock_error_irq <= 1'b0;
			erase_page_req <= 1'b0;
			erase_all_req  <= 1'b0;
			prog_busy      <= 1'b0;
			prog_cnt       <= '0;
			prog_page      <= '0;
		end else begin
			cmd_done       <= 1'b0;
			lock_error_irq <= 1'b0;
			erase_page_req <= 1'b0;
			erase_all_req  <= 1'b0;
			if (prog_busy) begin
				prog_cnt <= prog_cnt + (IW+1)'(1);
				if (prog_cnt == (IW+1)'(PAGE_WORDS - 1)) begin
					prog_busy <= 1'b0;
					cmd_done  <= 1'b1;
				end
			end else if (cmd_valid) begin
				if (cmd_modifies && cmd_locked) begin
					lock_error_irq <= 1'b1;
					cmd_done       <= 1'b1;
				end else if (cmd_code == nvm_map_pkg::CMD_PAGE_PROG) begin
					prog_busy <= 1'b1;
					prog_cnt  <= '0;
					prog_page <= cmd_page;
				end else if (cmd_code == nvm_map_pkg::CMD_PAGE_ERASE) begin
					erase_page_req <= 1'b1;
					prog_page      <= cmd_page;
					cmd_done       <= 1'b1;
				end else if (cmd_code == nvm_map_pkg::CMD_FULL_ERASE) begin
					erase_all_req <= 1'b1;
					cmd_done      <= 1'b1;
				end else if (cmd_code != nvm_map_pkg::CMD_NOP)
					cmd_done <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!system_reset_pin) begin
			prog_we   <= 1'b0;
			prog_idx  <= '0;
			prog_data <= 32'h0000_0000;
		end else begin
			prog_we   <= prog_busy;
			prog_idx  <= prog_cnt[IW-1:0];
			prog_data <= wbuf[prog_cnt[IW-1:0]];
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	a_unmapped_abort: assert property (@(posedge clk_sys) disable iff (!system_reset_pin)
		acc_valid && acc_addr[31:28] inside {4'h9, 4'hA, 4'hB, 4'hC, 4'hD, 4'hE} |=> acc_abort)
		else $error("unmapped area did not abort");
	a_ext_select: assert property (@(posedge clk_sys) disable iff (!system_reset_pin)
		acc_valid && acc_addr[31:28] == 4'h3 |=> ext_select_n == 8'hFB)
		else $error("wrong external select");
	a_periph_route: assert property (@(posedge clk_sys) disable iff (!system_reset_pin)
		acc_valid && acc_addr[31:28] == 4'hF |=> acc_target == nvm_map_pkg::TGT_PERIPH)
		else $error("peripheral area misrouted");
	a_rom_fixed: assert property (@(posedge clk_sys) disable iff (!system_reset_pin)
		acc_valid && acc_addr[31:20] == 12'h003 |=> acc_target == nvm_map_pkg::TGT_ROM)
		else $error("ROM base misrouted");
	a_boot_sram: assert property (@(posedge clk_sys) disable iff (!system_reset_pin)
		acc_valid && remapped && acc_addr[31:20] == 12'h000 |=> acc_target == nvm_map_pkg::TGT_SRAM)
		else $error("remapped zero not SRAM");
	a_lock_abort: assert property (@(posedge clk_sys) disable iff (!system_reset_pin)
		!prog_busy && cmd_valid && cmd_modifies && cmd_locked |=> lock_error_irq && !prog_busy && !erase_page_req)
		else $error("locked command not aborted");
	a_erase_clears: assert property (@(posedge clk_sys) disable iff (!system_reset_pin)
		erase_accept |=> lock_bits == '0 && general_purpose_nv_bit == 3'h0)
		else $error("erase pin did not clear bits");
	a_bod_follow: assert property (@(posedge clk_sys) disable iff (!system_reset_pin)
		##1 $changed(general_purpose_nv_bit[0]) |=> brownout_detector_en == $past(general_purpose_nv_bit[0]))
		else $error("detector enable not following bit");
	a_secure_refuse: assert property (@(posedge clk_sys) disable iff (!system_reset_pin)
		acc_valid && security && acc_from_debug && acc_addr[31:20] == 12'h001 |=> acc_abort)
		else $error("secured flash access passed");

	// A page program is taken, streams its first word two cycles later, and ends with done.
	sequence s_prog_take;
		!prog_busy && cmd_valid && cmd_code == nvm_map_pkg::CMD_PAGE_PROG && !cmd_locked;
	endsequence
	sequence s_prog_start;
		!prog_we ##1 (prog_we && prog_idx == '0);
	endsequence
	a_prog_stream: assert property (@(posedge clk_sys) disable iff (!system_reset_pin)
		s_prog_take |=> s_prog_start ##63 cmd_done)
		else $error("page program stream or done mistimed");
endmodule : nvm_map_ctrl

// *** logic/nvm_map_defs.svh ***
// Constants for the memory map decoder and non-volatile control block.
`ifndef NVM_MAP_DEFS_SVH
`define NVM_MAP_DEFS_SVH
`define AREA_MSB          31
`define AREA_LSB          28
`define AREA_INTERNAL     4'h0
`define AREA_EXT_FIRST    4'h1
`define AREA_EXT_LAST     4'h8
`define AREA_PERIPH       4'hF
`define REGION_MSB        27
`define REGION_LSB        20
`define REGION_BOOT       8'h00
`define REGION_FLASH      8'h01
`define REGION_SRAM       8'h02
`define REGION_ROM        8'h03
`define GPBIT_BOD_EN      0
`define GPBIT_BOD_RST_EN  1
`define GPBIT_BOOT_FLASH  2
`define GPBITS_RESET      3'h0
`define LOCK_RESET        32'h0000_0000
`define FAST_PROG_PATTERN 4'hB
`define ERASE_IGNORE_MS   100
`define ERASE_ACCEPT_MS   220
`define SLOW_CLK_HZ       32000
`define SYS_CLK_HZ        125000000
`define SLOW_DIV_CYCLES   (`SYS_CLK_HZ / `SLOW_CLK_HZ)
`define ERASE_ACCEPT_TICKS ((`ERASE_ACCEPT_MS * `SLOW_CLK_HZ + 999) / 1000)
`endif

// *** logic/nvm_map_pkg.sv ***
// Types for the memory map decoder and non-volatile control block.
package nvm_map_pkg;
	typedef enum logic [2:0] {
		TGT_NONE,
		TGT_SRAM,
		TGT_ROM,
		TGT_FLASH,
		TGT_EXT,
		TGT_PERIPH
	} target_e;
	typedef enum logic [3:0] {
		CMD_NOP,
		CMD_REMAP,
		CMD_SET_GPBIT,
		CMD_CLR_GPBIT,
		CMD_SET_LOCK,
		CMD_CLR_LOCK,
		CMD_SET_SECURITY,
		CMD_PAGE_PROG,
		CMD_PAGE_ERASE,
		CMD_FULL_ERASE
	} cmd_e;
endpackage : nvm_map_pkg
